// ### inc/uart_cfg.svh
// Register offsets, field positions, reset values and timing counts of the serial port pair.
// Included by both ends, the serial shifter and the bench, not by the package; holds definitions only.
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// Device registers, picked by the three select lines
`define REG_DATA      3'h0
`define REG_IRQ_EN    3'h1
`define REG_IRQ_ID    3'h2
`define REG_LINE_CTRL 3'h3
`define REG_MODEM_CTL 3'h4
`define REG_LINE_STAT 3'h5
`define REG_MODEM_STA 3'h6
`define REG_SCRATCH   3'h7

// Field positions
`define IEN_RX        0
`define IEN_TX        1
`define IEN_LINE      2
`define IEN_MODEM     3
`define LCTL_TX_EN    0
`define MCTL_TERM_RDY 0
`define MCTL_REQ_SEND 1
`define MCTL_IRQ_OE   3
`define MCTL_LOOP     4

// Reset values
`define IRQ_EN_RST    8'h00
`define LINE_CTRL_RST 8'h01
`define MODEM_CTL_RST 8'h00

// Serial timing: 8 data bits, no parity, one stop bit
`define CLK_NS        20
`define BIT_NS        8680
`define BIT_CYCLES    16'((`BIT_NS) / (`CLK_NS))
`define HALF_CYCLES   16'((`BIT_NS) / (`CLK_NS) / 2)

// Host strobe timing in clock cycles
`define HOST_SETUP    4'h2
`define HOST_STROBE   4'hc
`define HOST_HOLD     4'h4

// Host Avalon register byte offsets and interrupt status bit positions
`define HB_CMD        4'h0
`define HB_STATUS     4'h4
`define HB_IRQ_STAT   4'h8
`define HB_IRQ_MASK   4'hc
`define HB_IRQ_DONE   0
`define HB_IRQ_LINE   1

`endif

// ### inc/uart_pkg.sv
// Types shared by both ends of the serial port pair.
// Assumes uart_cfg.svh is on the include path.
package uart_pkg;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_START = 2'b01,
    S_DATA  = 2'b10,
    S_STOP  = 2'b11
  } ser_st_t;

  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_SETUP  = 2'b01,
    H_STROBE = 2'b10,
    H_HOLD   = 2'b11
  } host_st_t;

  typedef struct packed {
    ser_st_t     tx_st;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_idx;
    logic [7:0]  tx_sh;
    logic        tx_line;
    ser_st_t     rx_st;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_idx;
    logic [7:0]  rx_sh;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic        rx_ferr;
    logic        rx_brk;
  } ser_state_t;

  typedef struct packed {
    logic [18:0] sy1;
    logic [18:0] sy2;
    logic [18:0] sy3;
    logic [18:0] flt;
    logic        rd_act;
    logic        wr_act;
    logic [7:0]  rd_data;
    logic [7:0]  irq_en;
    logic [7:0]  line_ctrl;
    logic [7:0]  modem_ctl;
    logic [7:0]  scratch;
    logic [7:0]  thr;
    logic        thr_full;
    logic        tx_start;
    logic [7:0]  rbr;
    logic        rx_rdy;
    logic        overrun;
    logic        frame_err;
    logic        brk;
    logic [3:0]  msr_delta;
    logic        ser_out;
    logic        irq;
  } dev_state_t;

  typedef struct packed {
    host_st_t    st;
    logic [3:0]  cnt;
    logic [2:0]  sel;
    logic [7:0]  wdata;
    logic        is_read;
    logic [7:0]  rdata;
    logic [8:0]  sy1;
    logic [8:0]  sy2;
    logic [8:0]  sy3;
    logic [8:0]  flt;
    logic        ack;
    logic [31:0] rdout;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        doe;
  } host_state_t;

  // A synchronised bit takes a new value only once stages two and three agree
  function automatic logic [31:0] settle(input logic [31:0] s2, input logic [31:0] s3, input logic [31:0] f);
    settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
  endfunction

endpackage

// ### inc/uart_bus_if.sv
// Parallel host bus and interrupt pin between host end and device end.
// Resolves the shared data bus and the three-state interrupt from the enables.
`timescale 1ns/1ps
`default_nettype none
interface uart_bus_if;
  logic [2:0] reg_select_lines;
  logic       chip_select_n;
  logic       bus_read_strobe_n;
  logic       bus_write_strobe_n;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] data_bus;
  logic       host_irq_out;
  logic       host_irq_oe;
  logic       host_irq_line;

  // Undriven bus floats high; undriven interrupt is pulled low
  assign data_bus      = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hff);
  assign host_irq_line = host_irq_oe & host_irq_out;

  modport device_mp (
    input  reg_select_lines, chip_select_n, bus_read_strobe_n, bus_write_strobe_n, data_bus,
    output dev_data_out, dev_data_oe, host_irq_out, host_irq_oe
  );
  modport host_mp (
    output reg_select_lines, chip_select_n, bus_read_strobe_n, bus_write_strobe_n,
    output host_data_out, host_data_oe,
    input  data_bus, host_irq_line
  );
endinterface
`default_nettype wire

// ### logic/uart_serial.sv
// Serial shifter: one character transmitter and one receiver, 8 data bits, one stop bit.
// Assumes a receive input already synchronised to i_clk.
`timescale 1ns/1ps
`default_nettype none
module uart_serial (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_tx_start,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_tx_busy,
  output logic            o_tx_line,
  input  wire logic       i_rx_line,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_rx_ferr,
  output logic            o_rx_brk
);
  import uart_pkg::*;
  `include "uart_cfg.svh"

  ser_state_t q;
  ser_state_t n;
  logic       tx_end;
  logic       rx_end;

  always_comb begin
    n = q;
    n.rx_valid = 1'b0;
    tx_end = (q.tx_cnt == `BIT_CYCLES - 16'h0001);
    rx_end = (q.rx_cnt == `BIT_CYCLES - 16'h0001);
    n.tx_cnt = tx_end ? 16'h0000 : q.tx_cnt + 16'h0001;
    n.rx_cnt = rx_end ? 16'h0000 : q.rx_cnt + 16'h0001;
    case (q.tx_st)
      S_IDLE: begin
        n.tx_cnt = 16'h0000;
        if (i_tx_start) begin
          n.tx_sh = i_tx_byte;
          n.tx_st = S_START;
        end
      end
      S_START: if (tx_end) begin
        n.tx_idx = 3'h0;
        n.tx_st = S_DATA;
      end
      S_DATA: if (tx_end) begin
        n.tx_sh = {1'b1, q.tx_sh[7:1]};
        n.tx_idx = q.tx_idx + 3'h1;
        if (q.tx_idx == 3'h7) n.tx_st = S_STOP;
      end
      S_STOP: if (tx_end) n.tx_st = S_IDLE;
      default: n.tx_st = S_IDLE;
    endcase
    case (n.tx_st)
      S_START: n.tx_line = 1'b0;
      S_DATA:  n.tx_line = n.tx_sh[0];
      default: n.tx_line = 1'b1;
    endcase
    case (q.rx_st)
      S_IDLE: begin
        n.rx_cnt = 16'h0000;
        if (!i_rx_line) n.rx_st = S_START;
      end
      // Recheck at mid start bit so a short glitch is not taken for a character
      S_START: if (q.rx_cnt == `HALF_CYCLES - 16'h0001) begin
        n.rx_cnt = 16'h0000;
        n.rx_idx = 3'h0;
        n.rx_st = i_rx_line ? S_IDLE : S_DATA;
      end
      S_DATA: if (rx_end) begin
        n.rx_sh = {i_rx_line, q.rx_sh[7:1]};
        n.rx_idx = q.rx_idx + 3'h1;
        if (q.rx_idx == 3'h7) n.rx_st = S_STOP;
      end
      S_STOP: if (rx_end) begin
        n.rx_valid = 1'b1;
        n.rx_byte = q.rx_sh;
        n.rx_ferr = ~i_rx_line;
        n.rx_brk = ~i_rx_line & (q.rx_sh == 8'h00);
        n.rx_st = S_IDLE;
      end
      default: n.rx_st = S_IDLE;
    endcase
    if (i_sys_rst) begin
      n = '0;
      n.tx_line = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= n;
  end

  assign o_tx_busy  = (q.tx_st != S_IDLE);
  assign o_tx_line  = q.tx_line;
  assign o_rx_valid = q.rx_valid;
  assign o_rx_byte  = q.rx_byte;
  assign o_rx_ferr  = q.rx_ferr;
  assign o_rx_brk   = q.rx_brk;
endmodule
`default_nettype wire

// ### logic/uart_device.sv
// Device end: register file behind the strobed parallel bus, serial line, modem pins, interrupt pin.
// Assumes the bus pins arrive from another party; they are resynchronised here.
//
// How it works
// - Select lines pick the accessed register.
// - Eight-bit shared data bus, both directions.
// - Read strobe fall presents addressed register byte.
// - Write strobe rise stores bus byte.
// - Accesses count only with chip select low.
// - Interrupt pin floats until enabled by control.
// - Interrupt high on any enabled active source.
// - Serial output idles high, reset and disabled.
// - Loopback feeds transmitter into receiver, output idle.
// - Far end idles receive line high.
// - Request-to-send output, active low.
// - Terminal-ready output, active low.
// - Clear-to-send input, active low.
// - Reset restores every register default.
// - Other modem inputs active low status.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_device (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  uart_bus_if.device_mp    bus,
  output logic             o_serial_out_line,
  input  wire logic        i_serial_in_line,
  output logic             o_request_to_send_n,
  output logic             o_terminal_ready_n,
  input  wire logic        i_clear_to_send_n,
  input  wire logic        i_set_ready_n,
  input  wire logic        i_carrier_detect_n,
  input  wire logic        i_phone_bell_n
);
  import uart_pkg::*;
  `include "uart_cfg.svh"

  dev_state_t q;
  dev_state_t n;
  logic [18:0] pins;
  logic [7:0]  f_data;
  logic [2:0]  f_sel;
  logic        f_wr_n;
  logic        f_rd_n;
  logic        f_cs_n;
  logic        f_rx;
  logic [3:0]  modem_act;
  logic [7:0]  line_stat;
  logic [7:0]  irq_id;
  logic        rd_fall;
  logic        wr_fall;
  logic        wr_rise;
  logic        rx_src;
  logic        tx_busy;
  logic        tx_line;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_ferr;
  logic        rx_brk;
  logic        src_rx;
  logic        src_tx;
  logic        src_line;
  logic        src_modem;

  assign pins = {i_phone_bell_n, i_carrier_detect_n, i_set_ready_n, i_clear_to_send_n, i_serial_in_line,
                 bus.chip_select_n, bus.bus_read_strobe_n, bus.bus_write_strobe_n, bus.reg_select_lines,
                 bus.data_bus};
  assign f_data = q.flt[7:0];
  assign f_sel = q.flt[10:8];
  assign f_wr_n = q.flt[11];
  assign f_rd_n = q.flt[12];
  assign f_cs_n = q.flt[13];
  assign f_rx = q.flt[14];
  assign modem_act = ~q.flt[18:15];

  // Loopback swaps the pin for the transmitter's own line
  assign rx_src = q.modem_ctl[`MCTL_LOOP] ? tx_line : f_rx;

  uart_serial uart_serial_i (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_tx_start (q.tx_start),
    .i_tx_byte  (q.thr),
    .o_tx_busy  (tx_busy),
    .o_tx_line  (tx_line),
    .i_rx_line  (rx_src),
    .o_rx_valid (rx_valid),
    .o_rx_byte  (rx_byte),
    .o_rx_ferr  (rx_ferr),
    .o_rx_brk   (rx_brk)
  );

  assign line_stat = {1'b0, ~q.thr_full & ~tx_busy, ~q.thr_full, q.brk, q.frame_err, 1'b0, q.overrun, q.rx_rdy};

  assign src_rx    = q.irq_en[`IEN_RX] & q.rx_rdy;
  assign src_tx    = q.irq_en[`IEN_TX] & ~q.thr_full;
  assign src_line  = q.irq_en[`IEN_LINE] & (q.overrun | q.frame_err | q.brk);
  assign src_modem = q.irq_en[`IEN_MODEM] & (|q.msr_delta);

  // Highest priority source first; bit 0 high means nothing pending
  always_comb begin
    if (src_line) begin
      irq_id = 8'h06;
    end else if (src_rx) begin
      irq_id = 8'h04;
    end else if (src_tx) begin
      irq_id = 8'h02;
    end else if (src_modem) begin
      irq_id = 8'h00;
    end else begin
      irq_id = 8'h01;
    end
  end

  always_comb begin
    n = q;
    n.tx_start = 1'b0;
    n.sy1 = pins;
    n.sy2 = q.sy1;
    n.sy3 = q.sy2;
    n.flt = 19'(settle(32'(q.sy2), 32'(q.sy3), 32'(q.flt)));
    rd_fall = f_rd_n & ~n.flt[12] & ~n.flt[13];
    wr_fall = f_wr_n & ~n.flt[11] & ~n.flt[13];
    wr_rise = ~f_wr_n & n.flt[11] & q.wr_act;

    // Read: latch the byte once at the falling edge, clear-on-read effects follow
    if (rd_fall) begin
      n.rd_act = 1'b1;
      case (n.flt[10:8])
        `REG_DATA: begin
          n.rd_data = q.rbr;
          n.rx_rdy = 1'b0;
        end
        `REG_IRQ_EN:    n.rd_data = {4'h0, q.irq_en[3:0]};
        `REG_IRQ_ID:    n.rd_data = irq_id;
        `REG_LINE_CTRL: n.rd_data = q.line_ctrl;
        `REG_MODEM_CTL: n.rd_data = {3'h0, q.modem_ctl[4:0]};
        `REG_LINE_STAT: begin
          n.rd_data = line_stat;
          n.overrun = 1'b0;
          n.frame_err = 1'b0;
          n.brk = 1'b0;
        end
        `REG_MODEM_STA: begin
          n.rd_data = {modem_act, q.msr_delta};
          n.msr_delta = 4'h0;
        end
        default:        n.rd_data = q.scratch;
      endcase
    end else if (n.flt[12] | n.flt[13]) begin
      n.rd_act = 1'b0;
    end

    if (wr_fall) begin
      n.wr_act = 1'b1;
    end
    // Data and select settled long before the strobe rises, so take the filtered copy
    if (wr_rise) begin
      n.wr_act = 1'b0;
      case (f_sel)
        `REG_DATA: begin
          n.thr = f_data;
          n.thr_full = 1'b1;
        end
        `REG_IRQ_EN:    n.irq_en = {4'h0, f_data[3:0]};
        `REG_LINE_CTRL: n.line_ctrl = f_data;
        `REG_MODEM_CTL: n.modem_ctl = {3'h0, f_data[4:0]};
        `REG_SCRATCH:   n.scratch = f_data;
        default: ;
      endcase
    end

    if (q.thr_full & ~tx_busy & ~q.tx_start & q.line_ctrl[`LCTL_TX_EN]) begin
      n.tx_start = 1'b1;
      n.thr_full = 1'b0;
    end

    // Hardware events come last so they win over a clear in the same cycle
    if (rx_valid) begin
      n.overrun = n.overrun | q.rx_rdy;
      n.rbr = rx_byte;
      n.rx_rdy = 1'b1;
      n.frame_err = n.frame_err | rx_ferr;
      n.brk = n.brk | rx_brk;
    end
    n.msr_delta = n.msr_delta | ~(n.flt[18:15] ^ ~q.flt[18:15]);

    // Disabling mid-character must not leave a low bit standing on the pin
    n.ser_out = (q.modem_ctl[`MCTL_LOOP] | ~q.line_ctrl[`LCTL_TX_EN]) ? 1'b1 : tx_line;
    n.irq = src_rx | src_tx | src_line | src_modem;

    if (i_sys_rst) begin
      n = '0;
      n.sy1 = '1;
      n.sy2 = '1;
      n.sy3 = '1;
      n.flt = '1;
      n.irq_en = `IRQ_EN_RST;
      n.line_ctrl = `LINE_CTRL_RST;
      n.modem_ctl = `MODEM_CTL_RST;
      n.ser_out = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= n;
  end

  assign bus.dev_data_out = q.rd_data;
  assign bus.dev_data_oe  = q.rd_act & ~f_rd_n & ~f_cs_n;
  assign bus.host_irq_out = q.irq;
  assign bus.host_irq_oe  = q.modem_ctl[`MCTL_IRQ_OE];
  assign o_serial_out_line   = q.ser_out;
  assign o_request_to_send_n = ~q.modem_ctl[`MCTL_REQ_SEND];
  assign o_terminal_ready_n  = ~q.modem_ctl[`MCTL_TERM_RDY];
endmodule
`default_nettype wire

// ### logic/uart_host.sv
// Host end: Avalon-MM slave that turns software orders into strobed bus cycles on the device.
// Assumes the device drives data and interrupt from its own clock; both are resynchronised.
`timescale 1ns/1ps
`default_nettype none
module uart_host (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_irq,
  uart_bus_if.host_mp      bus
);
  import uart_pkg::*;
  `include "uart_cfg.svh"

  host_state_t q;
  host_state_t n;
  logic        req;
  logic        take;
  logic        done;

  assign req  = i_avs_read | i_avs_write;
  assign take = req & q.ack;

  always_comb begin
    n = q;
    done = 1'b0;
    n.sy1 = {bus.host_irq_line, bus.data_bus};
    n.sy2 = q.sy1;
    n.sy3 = q.sy2;
    n.flt = 9'(settle(32'(q.sy2), 32'(q.sy3), 32'(q.flt)));
    // One wait cycle gives readdata time to come from a flip-flop
    n.ack = req & ~q.ack;
    case (i_avs_address)
      `HB_CMD:      n.rdout = {15'h0000, q.is_read, 5'h00, q.sel, q.wdata};
      `HB_STATUS:   n.rdout = {15'h0000, q.flt[8], q.rdata, 7'h00, q.st != H_IDLE};
      `HB_IRQ_STAT: n.rdout = {30'h00000000, q.istat};
      `HB_IRQ_MASK: n.rdout = {30'h00000000, q.imask};
      default:      n.rdout = 32'h00000000;
    endcase

    n.cnt = q.cnt + 4'h1;
    case (q.st)
      H_IDLE: begin
        n.cnt = 4'h0;
        // A new order while busy is dropped
        if (take & i_avs_write & (i_avs_address == `HB_CMD)) begin
          n.wdata = i_avs_writedata[7:0];
          n.sel = i_avs_writedata[10:8];
          n.is_read = i_avs_writedata[16];
          n.cs_n = 1'b0;
          n.doe = ~i_avs_writedata[16];
          n.st = H_SETUP;
        end
      end
      H_SETUP: if (q.cnt == `HOST_SETUP - 4'h1) begin
        n.cnt = 4'h0;
        n.rd_n = ~q.is_read;
        n.wr_n = q.is_read;
        n.st = H_STROBE;
      end
      H_STROBE: if (q.cnt == `HOST_STROBE - 4'h1) begin
        n.cnt = 4'h0;
        if (q.is_read) n.rdata = q.flt[7:0];
        n.rd_n = 1'b1;
        n.wr_n = 1'b1;
        n.st = H_HOLD;
      end
      H_HOLD: if (q.cnt == `HOST_HOLD - 4'h1) begin
        n.cs_n = 1'b1;
        n.doe = 1'b0;
        done = 1'b1;
        n.st = H_IDLE;
      end
      default: n.st = H_IDLE;
    endcase

    if (take & i_avs_write & (i_avs_address == `HB_IRQ_MASK)) n.imask = i_avs_writedata[1:0];
    if (take & i_avs_write & (i_avs_address == `HB_IRQ_STAT)) n.istat = q.istat & ~i_avs_writedata[1:0];
    n.istat[`HB_IRQ_DONE] = n.istat[`HB_IRQ_DONE] | done;
    n.istat[`HB_IRQ_LINE] = n.istat[`HB_IRQ_LINE] | (n.flt[8] & ~q.flt[8]);

    if (i_sys_rst) begin
      n = '0;
      n.cs_n = 1'b1;
      n.rd_n = 1'b1;
      n.wr_n = 1'b1;
      n.sy1 = 9'h0ff;
      n.sy2 = 9'h0ff;
      n.sy3 = 9'h0ff;
      n.flt = 9'h0ff;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= n;
  end

  assign o_avs_readdata         = q.rdout;
  assign o_avs_waitrequest      = req & ~q.ack;
  assign o_irq                  = |(q.istat & q.imask);
  assign bus.reg_select_lines   = q.sel;
  assign bus.chip_select_n      = q.cs_n;
  assign bus.bus_read_strobe_n  = q.rd_n;
  assign bus.bus_write_strobe_n = q.wr_n;
  assign bus.host_data_out      = q.wdata;
  assign bus.host_data_oe       = q.doe;
endmodule
`default_nettype wire

// ### testbench/uart_bus_chk.sv
// Checker on the parallel bus between host end and device end.
// Instantiated by the bench beside the interface; sees only its signals.
`timescale 1ns/1ps
`default_nettype none
module uart_bus_chk (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic [2:0] reg_select_lines,
  input wire logic       chip_select_n,
  input wire logic       bus_read_strobe_n,
  input wire logic       bus_write_strobe_n,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe,
  input wire logic       host_irq_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Cycles since the write strobe was last low, saturating
  logic [4:0] since_wr_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) since_wr_q <= 5'h1f;
    else if (!bus_write_strobe_n) since_wr_q <= 5'h00;
    else if (since_wr_q != 5'h1f) since_wr_q <= since_wr_q + 5'h01;
  end

  AST_NO_CONTENTION: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  AST_ONE_STROBE: assert property (!(!bus_read_strobe_n && !bus_write_strobe_n))
    else $error("read and write strobes low together");
  AST_STROBE_CS: assert property ((!bus_read_strobe_n || !bus_write_strobe_n) |-> !chip_select_n)
    else $error("strobe low without chip select");
  AST_DEV_OE_START: assert property ($rose(dev_data_oe) |->
    $past(bus_read_strobe_n, 2) == 1'b0 && $past(chip_select_n, 2) == 1'b0)
    else $error("device drove bus without a selected read");
  AST_DEV_OE_END: assert property ($fell(dev_data_oe) |-> $past(bus_read_strobe_n, 2))
    else $error("device released bus during read strobe");
  AST_WR_LEN: assert property ($fell(bus_write_strobe_n) |->
    (!bus_write_strobe_n)[*8] ##1 (!bus_write_strobe_n)[*4] ##1 bus_write_strobe_n)
    else $error("write strobe not twelve cycles");
  AST_WR_STABLE: assert property ((!bus_write_strobe_n && !$fell(bus_write_strobe_n)) |->
    $stable(reg_select_lines) && $stable(host_data_out))
    else $error("select or data moved under write strobe");
  AST_WR_HOLD: assert property ($rose(bus_write_strobe_n) |->
    (host_data_oe && !chip_select_n)[*4] ##1 (chip_select_n && !host_data_oe))
    else $error("write data not held after strobe");
  AST_IRQ_OE_CAUSE: assert property ($rose(host_irq_oe) |-> since_wr_q < 5'h0a)
    else $error("interrupt pin enabled without a write");
  AST_RST_IDLE: assert property (disable iff (1'b0) i_sys_rst |=>
    chip_select_n && !dev_data_oe && !host_irq_oe)
    else $error("bus not idle after reset");
endmodule
`default_nettype wire

// ### testbench/test_uart_host_bus_and_pin_interface.sv
// Self-checking bench: host end and device end joined by the bus, driven over Avalon-MM.
// Assumes the package, interface, design files and uart_cfg.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg.svh"
module test_uart_host_bus_and_pin_interface;
  import uart_pkg::*;
  logic        i_clk;
  logic        i_sys_rst;
  logic [3:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        host_irq;
  logic        ser_out;
  logic        ser_in;
  logic        req_send_n;
  logic        term_rdy_n;
  logic        clr_send_n;
  logic        set_rdy_n;
  logic        carrier_n;
  logic        bell_n;
  int          checks = 0;
  int          miscompares = 0;

  uart_bus_if link ();
  uart_host uart_host_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .o_irq(host_irq), .bus(link));
  uart_device uart_device_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(link), .o_serial_out_line(ser_out),
    .i_serial_in_line(ser_in), .o_request_to_send_n(req_send_n), .o_terminal_ready_n(term_rdy_n),
    .i_clear_to_send_n(clr_send_n), .i_set_ready_n(set_rdy_n), .i_carrier_detect_n(carrier_n),
    .i_phone_bell_n(bell_n));
  uart_bus_chk uart_bus_chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .reg_select_lines(link.reg_select_lines),
    .chip_select_n(link.chip_select_n), .bus_read_strobe_n(link.bus_read_strobe_n),
    .bus_write_strobe_n(link.bus_write_strobe_n), .host_data_out(link.host_data_out),
    .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe), .host_irq_oe(link.host_irq_oe));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A used-up wait bound counts as a mismatch and ends the run
  task automatic limit(input string what, input int n, input int lim);
    if (n >= lim) begin
      check(what, 32'h0, 32'h1);
      wrap_up();
    end
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic av(input logic [3:0] a, input logic rd, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    av_addr <= a;
    av_wdata <= d;
    av_rd <= rd;
    av_wr <= !rd;
    do begin
      @(posedge i_clk);
      n++;
    end while (av_wait !== 1'b0 && n < 40);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    limit("waitrequest", n, 40);
  endtask

  // One device access via the host; waits on the done flag, then clears it
  task automatic acc(input logic [2:0] sel, input logic rd, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    int n;
    n = 0;
    av(`HB_CMD, 1'b0, {15'h0, rd, 5'h0, sel, d}, r);
    do begin
      av(`HB_IRQ_STAT, 1'b1, 32'h0, r);
      n++;
    end while (r[`HB_IRQ_DONE] !== 1'b1 && n < 100);
    limit("access done", n, 100);
    av(`HB_IRQ_STAT, 1'b0, 32'h1, r);
    av(`HB_STATUS, 1'b1, 32'h0, r);
    q = r[15:8];
  endtask

  task automatic rd_chk(input string what, input logic [2:0] sel, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] q;
    acc(sel, 1'b1, 8'h00, q);
    check(what, {24'h0, exp}, {24'h0, q & m});
  endtask

  task automatic ser_send(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      ser_in <= f[i];
      repeat (`BIT_CYCLES) @(posedge i_clk);
    end
  endtask

  // Counts cycles where the serial output leaves idle over eleven bit times
  task automatic quiet(input string what);
    int lows;
    lows = 0;
    repeat (11 * `BIT_CYCLES) begin
      @(posedge i_clk);
      if (ser_out !== 1'b1) lows++;
    end
    check(what, 32'h0, 32'(lows));
  endtask

  initial begin
    logic [7:0]  q;
    logic [31:0] r;
    logic [9:0]  frame;
    int          n;
    {av_addr, av_rd, av_wr, av_wdata} = '0;
    {ser_in, clr_send_n, set_rdy_n, carrier_n, bell_n} = 5'h1f;
    i_sys_rst = 1'b1;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;

    check("idle pins", 32'h7, {29'h0, req_send_n, term_rdy_n, ser_out});
    check("irq pin", 32'h0, {30'h0, link.host_irq_oe, link.host_irq_line});
    rd_chk("irq enable", `REG_IRQ_EN, 8'hff, `IRQ_EN_RST);
    rd_chk("line ctrl", `REG_LINE_CTRL, 8'hff, `LINE_CTRL_RST);
    rd_chk("modem ctrl", `REG_MODEM_CTL, 8'hff, `MODEM_CTL_RST);
    rd_chk("scratch", `REG_SCRATCH, 8'hff, 8'h00);
    $display("end of test: reset");

    for (int i = 0; i < 2; i++) begin
      acc(`REG_SCRATCH, 1'b0, i ? 8'h5a : 8'ha5, q);
      rd_chk("scratch", `REG_SCRATCH, 8'hff, i ? 8'h5a : 8'ha5);
    end
    $display("end of test: bus access");

    acc(`REG_MODEM_CTL, 1'b0, 8'h03, q);
    check("modem outs", 32'h0, {30'h0, req_send_n, term_rdy_n});
    clr_send_n <= 1'b0;
    bell_n <= 1'b0;
    // Status bits 7..4: bell, carrier, set ready, clear to send
    rd_chk("modem ins", `REG_MODEM_STA, 8'hf0, 8'h90);
    {clr_send_n, bell_n, set_rdy_n, carrier_n} <= 4'hc;
    rd_chk("modem ins", `REG_MODEM_STA, 8'hf0, 8'h60);
    $display("end of test: modem pins");

    acc(`REG_IRQ_EN, 1'b0, 8'h08, q);
    acc(`REG_MODEM_CTL, 1'b0, 8'h08, q);
    av(`HB_IRQ_MASK, 1'b0, 32'h2, r);
    check("irq quiet", 32'h0, {31'h0, link.host_irq_line});
    clr_send_n <= 1'b0;
    n = 0;
    while (host_irq !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    limit("irq wait", n, 100);
    check("irq line", 32'h1, {31'h0, link.host_irq_line});
    av(`HB_IRQ_MASK, 1'b0, 32'h0, r);
    @(posedge i_clk);
    check("irq masked", 32'h0, {31'h0, host_irq});
    av(`HB_IRQ_MASK, 1'b0, 32'h2, r);
    @(posedge i_clk);
    check("irq unmasked", 32'h1, {31'h0, host_irq});
    rd_chk("irq ident", `REG_IRQ_ID, 8'hff, 8'h00);
    acc(`REG_MODEM_STA, 1'b1, 8'h00, q);
    check("irq cleared", 32'h0, {31'h0, link.host_irq_line});
    av(`HB_IRQ_STAT, 1'b0, 32'h2, r);
    @(posedge i_clk);
    check("host irq", 32'h0, {31'h0, host_irq});
    acc(`REG_MODEM_CTL, 1'b0, 8'h00, q);
    check("irq enable pin", 32'h0, {31'h0, link.host_irq_oe});
    $display("end of test: interrupt");

    frame = {1'b1, 8'ha5, 1'b0};
    fork
      acc(`REG_DATA, 1'b0, 8'ha5, q);
      begin
        n = 0;
        while (ser_out !== 1'b0 && n < 200) begin
          @(posedge i_clk);
          n++;
        end
        limit("tx start", n, 200);
        repeat (`HALF_CYCLES) @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
          check("tx bit", {31'h0, frame[i]}, {31'h0, ser_out});
          repeat (`BIT_CYCLES) @(posedge i_clk);
        end
      end
    join
    ser_send({1'b1, 8'h96, 1'b0});
    rd_chk("rx ready", `REG_LINE_STAT, 8'h01, 8'h01);
    rd_chk("rx byte", `REG_DATA, 8'hff, 8'h96);
    ser_send(10'h000);
    ser_in <= 1'b1;
    rd_chk("break", `REG_LINE_STAT, 8'h18, 8'h18);
    $display("end of test: serial line");

    acc(`REG_MODEM_CTL, 1'b0, 8'h10, q);
    acc(`REG_DATA, 1'b0, 8'h3c, q);
    quiet("loop out");
    rd_chk("loop byte", `REG_DATA, 8'hff, 8'h3c);
    acc(`REG_MODEM_CTL, 1'b0, 8'h00, q);
    acc(`REG_LINE_CTRL, 1'b0, 8'h00, q);
    acc(`REG_DATA, 1'b0, 8'h00, q);
    quiet("tx off");
    $display("end of test: loopback and disable");
    wrap_up();
  end
endmodule
`default_nettype wire
